// ==== common/qdie_defines.svh ====
// Constants for the quadrature decoder interrupt enable block.
// Assumes a 32-bit APB slave with byte addresses.
`ifndef QDIE_DEFINES_SVH
`define QDIE_DEFINES_SVH

// Register byte offsets
`define QDIE_OFS_ENABLE_SET      12'h304
`define QDIE_OFS_ENABLE_CLEAR    12'h308

// Event bit positions in the enable mask
`define QDIE_BIT_SAMPLE_DONE     0
`define QDIE_BIT_REPORT_DONE     1
`define QDIE_BIT_SUM_OVERFLOW    2
`define QDIE_BIT_DOUBLE_REPORT   3
`define QDIE_BIT_STOPPED         4

// Widths and reset values
`define QDIE_NUM_EVENTS          5
`define QDIE_ADDR_W              12
`define QDIE_SUM_W               16
`define QDIE_DBL_W               4
`define QDIE_MASK_RESET          5'h00

`endif

// ==== common/qdie_pkg.sv ====
// Types for the quadrature decoder interrupt enable block.
// Assumes qdie_defines.svh is on the include path.
`include "qdie_defines.svh"

package qdie_pkg;

    typedef logic [`QDIE_NUM_EVENTS-1:0] qdie_events_t;

    typedef struct packed {
        logic                    psel;
        logic                    penable;
        logic                    pwrite;
        logic [`QDIE_ADDR_W-1:0] paddr;
        logic [31:0]             pwdata;
    } qdie_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } qdie_apb_rsp_t;

endpackage : qdie_pkg

// ==== rtl/qdie_irq_enable.sv ====
// Interrupt enable logic of the quadrature decoder, with APB register access.
// Assumes the decoder datapath drives single-cycle event pulses on mclk.
//
// Overview of operation
// - Writing ones to the set register enables those events; reads return the mask.
// - Writing ones to the clear register disables those events; reads return the mask.
// - Report event fires at period end only when the motion sum is nonzero.
// - Double report event fires at period end only when double count is nonzero.
// - Overflow event has its own mask bit, set and cleared independently.
`timescale 1ns/1ns
`include "qdie_defines.svh"

module qdie_irq_enable (
    input  wire logic                    mclk,                  // 10 MHz clock
    input  wire logic                    sys_rst,               // Sync reset, high
    input  wire qdie_pkg::qdie_apb_req_t apb_req,               // APB request
    output qdie_pkg::qdie_apb_rsp_t      apb_rsp,               // APB response
    input  wire logic                    sample_done_event,     // Sample ready pulse
    input  wire logic                    period_done,           // Report period samples collected
    input  wire logic [`QDIE_SUM_W-1:0]  motion_sum,            // Motion sum value
    input  wire logic [`QDIE_DBL_W-1:0]  double_transition_count, // Double transition count
    input  wire logic                    motion_sum_overflow_event, // Overflow pulse
    input  wire logic                    stopped_event,         // Stopped pulse
    input  wire qdie_pkg::qdie_events_t  event_clear,           // Clear of event flags
    output logic                         report_done_event,     // Report ready pulse
    output logic                         double_transition_report_event, // Double report pulse
    output qdie_pkg::qdie_events_t       event_flags,           // Sticky event flags
    output qdie_pkg::qdie_events_t       irq_enable,            // Enable mask
    output logic                         irq                    // Interrupt request
);

    // ------------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------------
    logic next_report_done_event;
    logic next_double_transition_report_event;

    always_comb
    begin
        next_report_done_event = period_done && (motion_sum != `QDIE_SUM_W'(0));
        next_double_transition_report_event = period_done &&
                                              (double_transition_count != `QDIE_DBL_W'(0));
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            report_done_event              <= 1'b0;
            double_transition_report_event <= 1'b0;
        end
        else
        begin
            report_done_event              <= next_report_done_event;
            double_transition_report_event <= next_double_transition_report_event;
        end
    end

    // ------------------------------------------------------------------
    // Sticky event flags
    // ------------------------------------------------------------------
    localparam qdie_pkg::qdie_events_t FLAG_RESET = '0;
    qdie_pkg::qdie_events_t            raised;

    always_comb
    begin
        raised                          = '0;
        raised[`QDIE_BIT_SAMPLE_DONE]   = sample_done_event;
        raised[`QDIE_BIT_REPORT_DONE]   = report_done_event;
        raised[`QDIE_BIT_SUM_OVERFLOW]  = motion_sum_overflow_event;
        raised[`QDIE_BIT_DOUBLE_REPORT] = double_transition_report_event;
        raised[`QDIE_BIT_STOPPED]       = stopped_event;
    end

    // Sample ready flag
    qdie_sticky_bit #(
        .RESET_VALUE (FLAG_RESET[`QDIE_BIT_SAMPLE_DONE])
    ) u_flag_sample (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (raised[`QDIE_BIT_SAMPLE_DONE]),
        .clear_in (event_clear[`QDIE_BIT_SAMPLE_DONE]),
        .value    (event_flags[`QDIE_BIT_SAMPLE_DONE])
    );

    // Report ready flag
    qdie_sticky_bit #(
        .RESET_VALUE (FLAG_RESET[`QDIE_BIT_REPORT_DONE])
    ) u_flag_report (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (raised[`QDIE_BIT_REPORT_DONE]),
        .clear_in (event_clear[`QDIE_BIT_REPORT_DONE]),
        .value    (event_flags[`QDIE_BIT_REPORT_DONE])
    );

    // Sum overflow flag
    qdie_sticky_bit #(
        .RESET_VALUE (FLAG_RESET[`QDIE_BIT_SUM_OVERFLOW])
    ) u_flag_overflow (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (raised[`QDIE_BIT_SUM_OVERFLOW]),
        .clear_in (event_clear[`QDIE_BIT_SUM_OVERFLOW]),
        .value    (event_flags[`QDIE_BIT_SUM_OVERFLOW])
    );

    // Double report flag
    qdie_sticky_bit #(
        .RESET_VALUE (FLAG_RESET[`QDIE_BIT_DOUBLE_REPORT])
    ) u_flag_double (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (raised[`QDIE_BIT_DOUBLE_REPORT]),
        .clear_in (event_clear[`QDIE_BIT_DOUBLE_REPORT]),
        .value    (event_flags[`QDIE_BIT_DOUBLE_REPORT])
    );

    // Stopped flag
    qdie_sticky_bit #(
        .RESET_VALUE (FLAG_RESET[`QDIE_BIT_STOPPED])
    ) u_flag_stopped (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (raised[`QDIE_BIT_STOPPED]),
        .clear_in (event_clear[`QDIE_BIT_STOPPED]),
        .value    (event_flags[`QDIE_BIT_STOPPED])
    );

    // ------------------------------------------------------------------
    // APB slave and enable mask
    // ------------------------------------------------------------------
    localparam qdie_pkg::qdie_events_t MASK_RESET = `QDIE_MASK_RESET;
    logic                              hit_set;
    logic                              hit_clear;
    logic                              access;
    logic                              setup;
    logic                              write_set;
    logic                              write_clear;
    qdie_pkg::qdie_events_t            wmask;
    qdie_pkg::qdie_events_t            mask_set;
    qdie_pkg::qdie_events_t            mask_clear;

    always_comb
    begin
        hit_set   = 1'b0;
        hit_clear = 1'b0;
        case (apb_req.paddr)
            `QDIE_OFS_ENABLE_SET:
                hit_set   = 1'b1;
            `QDIE_OFS_ENABLE_CLEAR:
                hit_clear = 1'b1;
            default:
            begin
                hit_set   = 1'b0;
                hit_clear = 1'b0;
            end
        endcase
        setup       = apb_req.psel && !apb_req.penable;
        access      = apb_req.psel && apb_req.penable;
        write_set   = access && apb_req.pwrite && hit_set;
        write_clear = access && apb_req.pwrite && hit_clear;
        wmask       = apb_req.pwdata[`QDIE_NUM_EVENTS-1:0];
        mask_set    = write_set ? wmask : '0;
        mask_clear  = write_clear ? wmask : '0;
    end

    // Sample ready enable
    qdie_sticky_bit #(
        .RESET_VALUE (MASK_RESET[`QDIE_BIT_SAMPLE_DONE])
    ) u_mask_sample (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (mask_set[`QDIE_BIT_SAMPLE_DONE]),
        .clear_in (mask_clear[`QDIE_BIT_SAMPLE_DONE]),
        .value    (irq_enable[`QDIE_BIT_SAMPLE_DONE])
    );

    // Report ready enable
    qdie_sticky_bit #(
        .RESET_VALUE (MASK_RESET[`QDIE_BIT_REPORT_DONE])
    ) u_mask_report (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (mask_set[`QDIE_BIT_REPORT_DONE]),
        .clear_in (mask_clear[`QDIE_BIT_REPORT_DONE]),
        .value    (irq_enable[`QDIE_BIT_REPORT_DONE])
    );

    qdie_sticky_bit #(
        .RESET_VALUE (MASK_RESET[`QDIE_BIT_SUM_OVERFLOW])
    ) u_mask_overflow (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (mask_set[`QDIE_BIT_SUM_OVERFLOW]),
        .clear_in (mask_clear[`QDIE_BIT_SUM_OVERFLOW]),
        .value    (irq_enable[`QDIE_BIT_SUM_OVERFLOW])
    );

    // Double report enable
    qdie_sticky_bit #(
        .RESET_VALUE (MASK_RESET[`QDIE_BIT_DOUBLE_REPORT])
    ) u_mask_double (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (mask_set[`QDIE_BIT_DOUBLE_REPORT]),
        .clear_in (mask_clear[`QDIE_BIT_DOUBLE_REPORT]),
        .value    (irq_enable[`QDIE_BIT_DOUBLE_REPORT])
    );

    // Stopped enable
    qdie_sticky_bit #(
        .RESET_VALUE (MASK_RESET[`QDIE_BIT_STOPPED])
    ) u_mask_stopped (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (mask_set[`QDIE_BIT_STOPPED]),
        .clear_in (mask_clear[`QDIE_BIT_STOPPED]),
        .value    (irq_enable[`QDIE_BIT_STOPPED])
    );

    // ------------------------------------------------------------------
    // Read data and error response
    // ------------------------------------------------------------------
    logic [31:0] read_word;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic [31:0] prdata;
    logic        pslverr;

    always_comb
    begin
        read_word                       = 32'h00000000;
        read_word[`QDIE_NUM_EVENTS-1:0] = irq_enable;
        next_prdata                     = prdata;
        next_pslverr                    = pslverr;
        if (setup)
        begin
            next_pslverr = !(hit_set || hit_clear);
            next_prdata  = (hit_set || hit_clear) ? read_word : 32'h00000000;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    always_comb
    begin
        apb_rsp.prdata  = prdata;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = pslverr && access;
    end

    // ------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------
    // any enabled flag
    assign irq = |(event_flags & irq_enable);

endmodule : qdie_irq_enable

// ----------------------------------------------------------------------
// One stored bit with set and clear
// ----------------------------------------------------------------------
module qdie_sticky_bit #(
    parameter logic RESET_VALUE = 1'b0  // Value after reset
) (
    input  wire logic mclk,     // Clock
    input  wire logic sys_rst,  // Sync reset, high
    input  wire logic set_in,   // Set request
    input  wire logic clear_in, // Clear request
    output logic      value     // Stored bit
);

    logic next_value;

    always_comb
    begin
        next_value = value;
        if (clear_in)
            next_value = 1'b0;
        // Set wins over a same-cycle clear
        if (set_in)
            next_value = 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            value <= RESET_VALUE;
        else
            value <= next_value;
    end

endmodule : qdie_sticky_bit

// ==== verification/qdie_irq_enable_checker.sv ====
// Port assertions for the interrupt enable block.
// Assumes a bind onto qdie_irq_enable.
`timescale 1ns/1ns
`include "qdie_defines.svh"
module qdie_checker (
    input wire logic                    mclk,         // Clock
    input wire logic                    sys_rst,      // Reset
    input wire qdie_pkg::qdie_apb_req_t apb_req,      // Bus in
    input wire logic                    period_done,  // Period end
    input wire logic [`QDIE_SUM_W-1:0]  motion_sum,   // Sum
    input wire logic [`QDIE_DBL_W-1:0]  double_transition_count, // Count
    input wire logic                    report_done_event, // Report
    input wire logic                    double_transition_report_event, // Double
    input wire qdie_pkg::qdie_events_t  event_flags,  // Flags
    input wire qdie_pkg::qdie_events_t  irq_enable,   // Mask
    input wire logic                    irq           // Request
);
    logic wr;
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    property p_set;
        wr && apb_req.paddr == `QDIE_OFS_ENABLE_SET
        |=> irq_enable == ($past(irq_enable) | $past(apb_req.pwdata[4:0]));
    endproperty
    a_set: assert property (p_set) else $error("set write wrong");
    property p_clr;
        wr && apb_req.paddr == `QDIE_OFS_ENABLE_CLEAR
        |=> irq_enable == ($past(irq_enable) & ~$past(apb_req.pwdata[4:0]));
    endproperty
    a_clr: assert property (p_clr) else $error("clear write wrong");
    property p_rep;
        period_done |=> report_done_event == ($past(motion_sum) != 16'h0000);
    endproperty
    a_rep: assert property (p_rep) else $error("report event wrong");
    property p_dbl;
        period_done |=> double_transition_report_event == ($past(double_transition_count) != 4'h0);
    endproperty
    a_dbl: assert property (p_dbl) else $error("double event wrong");
    property p_ovf;
        wr && !apb_req.pwdata[2] |=> $stable(irq_enable[2]);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow bit moved");
    property p_irq;
        irq == |(event_flags & irq_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("irq wrong");
endmodule : qdie_checker

// ==== verification/test_qdie_irq_enable.sv ====
// Self-checking bench for the interrupt enable block.
// Assumes the package and header are on the path.
`timescale 1ns/1ns
`include "qdie_defines.svh"
module test_qdie_irq_enable;
    logic                    mclk = 1'b0;
    logic                    sys_rst = 1'b1;
    logic [4:0]              pulse = 5'h00;
    logic [4:0]              ev_clr = 5'h00;
    logic [15:0]             sum = 16'h0000;
    logic [3:0]              dbl = 4'h0;
    logic [4:0]              mask = 5'h00;
    logic [31:0]             d;
    logic [32:0]             q[$];
    qdie_pkg::qdie_apb_req_t req = '0;
    qdie_pkg::qdie_apb_rsp_t rsp;
    qdie_pkg::qdie_events_t  flags;
    logic                    irq;
    int                      err_total = 0;
    int                      comparisons = 0;
    int                      i;
    integer                  seed = 26168;
    localparam logic [11:0]  set_ofs = `QDIE_OFS_ENABLE_SET;
    localparam logic [11:0]  clr_ofs = `QDIE_OFS_ENABLE_CLEAR;
    qdie_irq_enable dut (.mclk(mclk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
        .sample_done_event(pulse[0]), .period_done(pulse[1]), .motion_sum(sum),
        .double_transition_count(dbl), .motion_sum_overflow_event(pulse[2]),
        .stopped_event(pulse[4]), .event_clear(ev_clr), .report_done_event(),
        .double_transition_report_event(), .event_flags(flags), .irq_enable(), .irq(irq));
    initial forever #50 mclk = ~mclk;
    task check(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task end_sim;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
        @(posedge mclk);
        req <= {1'b1, 1'b0, w, a, dat};
        if (!w)
            q.push_back((a == set_ofs || a == clr_ofs) ? {28'h0, mask} : {1'b1, 32'h0});
        else if (a == set_ofs)
            mask = mask | dat[4:0];
        else if (a == clr_ofs)
            mask = mask & ~dat[4:0];
        @(posedge mclk);
        req.penable <= 1'b1;
        do @(posedge mclk); while (rsp.pready !== 1'b1);
        req <= '0;
    endtask : apb
    always @(posedge mclk)
        if (req.psel & req.penable & !req.pwrite & rsp.pready)
            check({rsp.pslverr, rsp.prdata}, q.pop_front());
    initial
    begin
        #400000;
        err_total++;
        end_sim;
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(0, set_ofs, 0);
        apb(0, clr_ofs, 0);
        for (i = 0; i < 24; i++)
        begin
            d = $random(seed);
            apb(1, i[0] ? clr_ofs : set_ofs, i == 5 ? 32'h0 : d);
            apb(0, i[1] ? clr_ofs : set_ofs, 0);
        end
        apb(1, 12'h300, 32'hffffffff);
        apb(0, 12'h30c, 0);
        apb(0, set_ofs, 0);
        for (i = 0; i < 6; i++)
        begin
            @(posedge mclk);
            pulse <= (i == 3 || i == 5) ? 5'h02 : 5'h01 << i;
            sum <= (i == 1) ? 16'h8000 : 16'h0000;
            dbl <= (i == 3) ? 4'h8 : 4'h0;
            @(posedge mclk);
            pulse <= 5'h00;
            repeat (2) @(posedge mclk);
            #1 check(flags, i < 5 ? 5'h01 << i : 5'h00);
            check(irq, i < 5 && mask[i]);
            ev_clr <= 5'h1f;
            @(posedge mclk);
            ev_clr <= 5'h00;
        end
        end_sim;
    end
endmodule : test_qdie_irq_enable
bind qdie_irq_enable qdie_checker chk (.mclk, .sys_rst, .apb_req, .period_done, .motion_sum,
    .double_transition_count, .report_done_event, .double_transition_report_event,
    .event_flags, .irq_enable, .irq);
